// ### verilog/ict_capture_timer.v
`timescale 1ns/1ps
`include "ict_defines.vh"

// Function
// R1: timer halts in idle when idle-halt set
// R2: gate accumulates on internal clock only
// R3: prescale codes divide by 1, 8, 64, 256
// R4: source bit selects external rising edges
// R5: control write while running clears prescaler
// R6: timebase select picks sampled counter
// R7: interrupt after 1 to 4 captures
// R8: software routes capture input to pin; not done here, capture_input comes straight from its port
// R9: mode field selects capture edge behaviour
// R10: buffer-not-empty, overflow flags; idle halt
module ict_capture_timer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        timer_external_clock_pin,
    input  wire        timer_gate_pin,
    input  wire        capture_input,
    input  wire        idle_mode,
    input  wire        sleep_mode,
    input  wire [15:0] timer2_count,
    input  wire [15:0] timer4_count,
    input  wire [15:0] timer5_count,
    output reg         irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    reg  [15:0] tmr_ctrl_reg;
    reg  [15:0] tmr_count_reg;
    reg  [7:0]  tmr_ps_reg;
    reg  [15:0] sys_count_reg;
    reg  [15:0] cap_ctrl_reg;
    reg  [15:0] buf_mem [0:3];
    reg  [1:0]  buf_wr_reg;
    reg  [1:0]  buf_rd_reg;
    reg  [2:0]  buf_fill_reg;
    reg         cap_ovf_reg;
    reg  [3:0]  cap_ps_reg;
    reg  [1:0]  cap_cpi_reg;
    reg  [2:0]  st_reg;
    reg  [2:0]  st_next;
    reg  [2:0]  mask_reg;
    reg  [2:0]  ext_sync_reg;
    reg  [1:0]  gate_sync_reg;
    reg  [2:0]  cap_sync_reg;
    reg  [15:0] tb_value;
    reg         edge_hit;
    reg  [31:0] rd_value;
    reg         rd_ok;

    wire        wr_fire   = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    wire        rd_fire   = s_axi_arready & s_axi_arvalid;
    wire [4:0]  wr_addr   = s_axi_awaddr[`ICT_ADDR_W-1:0];
    wire [4:0]  rd_addr   = s_axi_araddr[`ICT_ADDR_W-1:0];
    wire [15:0] wr_data   = byte_merge(s_axi_wdata[15:0], s_axi_wstrb[1:0]);
    wire        wr_tctrl  = wr_fire & (wr_addr == `ICT_ADDR_TMR_CTRL);
    wire        wr_tcount = wr_fire & (wr_addr == `ICT_ADDR_TMR_COUNT);
    wire        wr_cctrl  = wr_fire & (wr_addr == `ICT_ADDR_CAP_CTRL);
    wire        wr_stat   = wr_fire & (wr_addr == `ICT_ADDR_IRQ_STAT);
    wire        wr_mask   = wr_fire & (wr_addr == `ICT_ADDR_IRQ_MASK);
    wire        rd_pop    = rd_fire & (rd_addr == `ICT_ADDR_CAP_BUF) & (buf_fill_reg != 3'h0);

    // byte-lane merge of the low half-word
    function [15:0] byte_merge;
        input [15:0] data;
        input [1:0]  strb;
        begin
            byte_merge = {strb[1] ? data[15:8] : 8'h00, strb[0] ? data[7:0] : 8'h00};
        end
    endfunction

    // does a low address hit a mapped register
    function addr_mapped;
        input [4:0] addr;
        begin
            addr_mapped = (addr == `ICT_ADDR_TMR_CTRL) || (addr == `ICT_ADDR_TMR_COUNT) ||
                          (addr == `ICT_ADDR_CAP_CTRL) || (addr == `ICT_ADDR_CAP_BUF) ||
                          (addr == `ICT_ADDR_IRQ_STAT) || (addr == `ICT_ADDR_IRQ_MASK);
        end
    endfunction

    // prescale terminal count per code
    function [7:0] ps_limit;
        input [1:0] code;
        begin
            case (code)
                `ICT_PS_DIV1:  ps_limit = `ICT_PS_LIM_1;
                `ICT_PS_DIV8:  ps_limit = `ICT_PS_LIM_8;
                `ICT_PS_DIV64: ps_limit = `ICT_PS_LIM_64;
                default:       ps_limit = `ICT_PS_LIM_256;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, first stage feeds only the second

    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync_reg  <= 3'h0;
            gate_sync_reg <= 2'h0;
            cap_sync_reg  <= 3'h0;
        end else begin
            ext_sync_reg  <= {ext_sync_reg[1:0], timer_external_clock_pin};
            gate_sync_reg <= {gate_sync_reg[0], timer_gate_pin};
            cap_sync_reg  <= {cap_sync_reg[1:0], capture_input};
        end
    end

    wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
    wire cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2];
    wire cap_fall = ~cap_sync_reg[1] & cap_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////////
    // timer source, gating and halting

    wire tmr_src_ext = tmr_ctrl_reg[`ICT_TMR_SRC];
    wire tmr_tick    = tmr_src_ext ? ext_rise :                                // R4
                       (tmr_ctrl_reg[`ICT_TMR_GATE] ? gate_sync_reg[1] : 1'b1); // R2
    wire tmr_halt    = ~tmr_ctrl_reg[`ICT_TMR_RUN] |
                       (tmr_ctrl_reg[`ICT_TMR_IDLE] & idle_mode);              // R1
    wire tmr_ps_end  = tmr_ps_reg == ps_limit(tmr_ctrl_reg[`ICT_TMR_PS_HI:`ICT_TMR_PS_LO]);
    wire tmr_inc     = ~tmr_halt & tmr_tick & tmr_ps_end;
    wire tmr_ovf     = tmr_inc & (tmr_count_reg == 16'hffff);

    // timer control, prescaler and count
    always @(posedge aclk) begin
        if (!aresetn) begin
            tmr_ctrl_reg  <= `ICT_TMR_RESET;
            tmr_ps_reg    <= 8'h00;
            tmr_count_reg <= 16'h0000;
        end else begin
            if (wr_tctrl)
                tmr_ctrl_reg <= wr_data & `ICT_TMR_WMASK;
            if (wr_tctrl && tmr_ctrl_reg[`ICT_TMR_RUN])
                tmr_ps_reg <= 8'h00;                                           // R5
            else if (!tmr_halt && tmr_tick)
                tmr_ps_reg <= tmr_ps_end ? 8'h00 : tmr_ps_reg + 8'h01;         // R3
            if (wr_tcount)
                tmr_count_reg <= wr_data;
            else if (tmr_inc)
                tmr_count_reg <= tmr_count_reg + 16'h0001;
        end
    end

    // free-running system timebase
    always @(posedge aclk) begin
        if (!aresetn)
            sys_count_reg <= 16'h0000;
        else
            sys_count_reg <= sys_count_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture timebase and edge selection

    wire [2:0] cap_mode = cap_ctrl_reg[`ICT_CAP_MODE_HI:`ICT_CAP_MODE_LO];
    wire [1:0] cap_cpi  = cap_ctrl_reg[`ICT_CAP_CPI_HI:`ICT_CAP_CPI_LO];
    wire       cap_halt = cap_ctrl_reg[`ICT_CAP_IDLE] & idle_mode;             // R10

    // timebase mux, reserved codes sample zero
    always @* begin
        case (cap_ctrl_reg[`ICT_CAP_TB_HI:`ICT_CAP_TB_LO])                     // R6
            `ICT_TB_SYS:  tb_value = sys_count_reg;
            `ICT_TB_TMR1: tb_value = tmr_count_reg;
            `ICT_TB_TMR5: tb_value = timer5_count;
            `ICT_TB_TMR4: tb_value = timer4_count;
            `ICT_TB_TMR2: tb_value = timer2_count;
            default:      tb_value = 16'h0000;
        endcase
    end

    // edge qualifying per mode
    always @* begin
        case (cap_mode)                                                        // R9
            `ICT_MODE_BOTH:   edge_hit = cap_rise | cap_fall;
            `ICT_MODE_FALL:   edge_hit = cap_fall;
            `ICT_MODE_RISE:   edge_hit = cap_rise;
            `ICT_MODE_RISE4:  edge_hit = cap_rise & (cap_ps_reg == `ICT_CAP_LIM_4);
            `ICT_MODE_RISE16: edge_hit = cap_rise & (cap_ps_reg == `ICT_CAP_LIM_16);
            default:          edge_hit = 1'b0;
        endcase
    end

    wire cap_pre   = (cap_mode == `ICT_MODE_RISE4) | (cap_mode == `ICT_MODE_RISE16);
    wire cap_store = edge_hit & ~cap_halt;
    wire buf_full  = buf_fill_reg == `ICT_BUF_DEPTH;
    wire buf_push  = cap_store & ~buf_full;
    wire cap_irq_ev = (cap_store & ((cap_mode == `ICT_MODE_BOTH) | (cap_cpi_reg == cap_cpi))) |
                      ((cap_mode == `ICT_MODE_WAKE) & cap_rise & (idle_mode | sleep_mode)); // R9

    ////////////////////////////////////////////////////////////////////////////
    // capture control, prescaler, count per interrupt, buffer

    always @(posedge aclk) begin
        if (!aresetn) begin
            cap_ctrl_reg <= `ICT_CAP_RESET;
            cap_ps_reg   <= 4'h0;
            cap_cpi_reg  <= 2'h0;
            buf_wr_reg   <= 2'h0;
            buf_rd_reg   <= 2'h0;
            buf_fill_reg <= 3'h0;
            cap_ovf_reg  <= 1'b0;
        end else begin
            if (wr_cctrl)
                cap_ctrl_reg <= wr_data & `ICT_CAP_WMASK;
            if (cap_mode == `ICT_MODE_OFF) begin
                // module off: flush buffer and flags
                cap_ps_reg   <= 4'h0;
                cap_cpi_reg  <= 2'h0;
                buf_wr_reg   <= 2'h0;
                buf_rd_reg   <= 2'h0;
                buf_fill_reg <= 3'h0;
                cap_ovf_reg  <= 1'b0;                                          // R10
            end else begin
                if (cap_pre && cap_rise && !cap_halt)
                    cap_ps_reg <= edge_hit ? 4'h0 : cap_ps_reg + 4'h1;
                if (cap_store && cap_mode != `ICT_MODE_BOTH)
                    cap_cpi_reg <= (cap_cpi_reg == cap_cpi) ? 2'h0 : cap_cpi_reg + 2'h1; // R7
                if (buf_push)
                    buf_wr_reg <= buf_wr_reg + 2'h1;
                if (rd_pop)
                    buf_rd_reg <= buf_rd_reg + 2'h1;
                if (buf_push && !rd_pop)
                    buf_fill_reg <= buf_fill_reg + 3'h1;
                else if (rd_pop && !buf_push)
                    buf_fill_reg <= buf_fill_reg - 3'h1;
                if (cap_store && buf_full)
                    cap_ovf_reg <= 1'b1;                                       // R10
            end
        end
    end

    // buffer storage
    always @(posedge aclk) begin
        if (buf_push && cap_mode != `ICT_MODE_OFF)
            buf_mem[buf_wr_reg] <= tb_value;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, set wins over write-one clear

    always @* begin
        st_next = st_reg;
        if (wr_stat)
            st_next = st_next & ~wr_data[`ICT_ST_W-1:0];
        if (cap_irq_ev && cap_mode != `ICT_MODE_OFF)
            st_next[`ICT_ST_CAP] = 1'b1;
        if (tmr_ovf)
            st_next[`ICT_ST_TOVF] = 1'b1;
        if (cap_store && buf_full && cap_mode != `ICT_MODE_OFF)
            st_next[`ICT_ST_COVF] = 1'b1;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            st_reg   <= 3'h0;
            mask_reg <= 3'h0;
            irq      <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (wr_mask)
                mask_reg <= wr_data[`ICT_ST_W-1:0];
            irq <= |(st_next & (wr_mask ? wr_data[`ICT_ST_W-1:0] : mask_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    always @* begin
        rd_value = 32'h0000_0000;
        rd_ok    = addr_mapped(rd_addr);
        case (rd_addr)
            `ICT_ADDR_TMR_CTRL:  rd_value[15:0] = tmr_ctrl_reg;
            `ICT_ADDR_TMR_COUNT: rd_value[15:0] = tmr_count_reg;
            `ICT_ADDR_CAP_CTRL: begin
                rd_value[15:0]       = cap_ctrl_reg;
                rd_value[`ICT_CAP_OVF] = cap_ovf_reg;
                rd_value[`ICT_CAP_BNE] = buf_fill_reg != 3'h0;                 // R10
            end
            `ICT_ADDR_CAP_BUF:   rd_value[15:0] = (|buf_fill_reg) ? buf_mem[buf_rd_reg] : 16'h0000;
            `ICT_ADDR_IRQ_STAT:  rd_value[`ICT_ST_W-1:0] = st_reg;
            `ICT_ADDR_IRQ_MASK:  rd_value[`ICT_ST_W-1:0] = mask_reg;
            default:             rd_value = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite handshakes, one write and one read at a time

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ICT_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `ICT_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_mapped(wr_addr) ? `ICT_RESP_OKAY : `ICT_RESP_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_value;
                s_axi_rresp  <= rd_ok ? `ICT_RESP_OKAY : `ICT_RESP_SLVERR;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ### verilog/ict_defines.vh
`ifndef ICT_DEFINES_VH
`define ICT_DEFINES_VH

// register byte addresses (low address bits)
`define ICT_ADDR_W          5
`define ICT_ADDR_TMR_CTRL   5'h00
`define ICT_ADDR_TMR_COUNT  5'h04
`define ICT_ADDR_CAP_CTRL   5'h08
`define ICT_ADDR_CAP_BUF    5'h0c
`define ICT_ADDR_IRQ_STAT   5'h10
`define ICT_ADDR_IRQ_MASK   5'h14

// timer control fields
`define ICT_TMR_RUN         15
`define ICT_TMR_IDLE        13
`define ICT_TMR_GATE        6
`define ICT_TMR_PS_HI       5
`define ICT_TMR_PS_LO       4
`define ICT_TMR_SYNC        2
`define ICT_TMR_SRC         1
`define ICT_TMR_WMASK       16'ha076
`define ICT_TMR_RESET       16'h0000

// capture control fields
`define ICT_CAP_IDLE        13
`define ICT_CAP_TB_HI       12
`define ICT_CAP_TB_LO       10
`define ICT_CAP_CPI_HI      6
`define ICT_CAP_CPI_LO      5
`define ICT_CAP_OVF         4
`define ICT_CAP_BNE         3
`define ICT_CAP_MODE_HI     2
`define ICT_CAP_MODE_LO     0
`define ICT_CAP_WMASK       16'h3c67
`define ICT_CAP_RESET       16'h0000

// capture modes
`define ICT_MODE_OFF        3'h0
`define ICT_MODE_BOTH       3'h1
`define ICT_MODE_FALL       3'h2
`define ICT_MODE_RISE       3'h3
`define ICT_MODE_RISE4      3'h4
`define ICT_MODE_RISE16     3'h5
`define ICT_MODE_WAKE       3'h7

// capture timebase codes
`define ICT_TB_TMR2         3'h1
`define ICT_TB_TMR4         3'h2
`define ICT_TB_TMR5         3'h3
`define ICT_TB_TMR1         3'h4
`define ICT_TB_SYS          3'h7

// prescale codes and terminal counts
`define ICT_PS_DIV1         2'h0
`define ICT_PS_DIV8         2'h1
`define ICT_PS_DIV64        2'h2
`define ICT_PS_LIM_1        8'h00
`define ICT_PS_LIM_8        8'h07
`define ICT_PS_LIM_64       8'h3f
`define ICT_PS_LIM_256      8'hff
`define ICT_CAP_LIM_4       4'h3
`define ICT_CAP_LIM_16      4'hf

// capture buffer
`define ICT_BUF_DEPTH       3'h4

// interrupt status bits
`define ICT_ST_W            3
`define ICT_ST_CAP          0
`define ICT_ST_TOVF         1
`define ICT_ST_COVF         2

// axi responses
`define ICT_RESP_OKAY       2'h0
`define ICT_RESP_SLVERR     2'h2

`endif

// ### dv/ict_capture_timer_chk.sv
`timescale 1ns/1ps
module ict_capture_timer_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // handshake steps
    sequence wr_take;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write ready longer than one cycle");
    aw_pair_a: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready apart");
    aw_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid |=> s_axi_awready)
        else $error("write not taken in time");
    wr_resp_a: assert property (wr_take |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response late");
    b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    ar_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready)
        else $error("read not taken in time");
    rd_resp_a: assert property (rd_take |=> s_axi_rvalid ##1 !s_axi_rready || !s_axi_rvalid)
        else $error("read data late");
    r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    rst_clean_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule

bind ict_capture_timer ict_capture_timer_chk i_ict_capture_timer_chk (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .irq           (irq)
);

// ### dv/ict_pin_model.sv
`timescale 1ns/1ps
module ict_pin_model (
    input wire aclk,
    output logic cap_pin,
    output logic ext_pin
);
    // both lines idle low, external clock still outside bursts
    initial begin
        cap_pin = 1'b0;
        ext_pin = 1'b0;
    end
    // full pulses, each level held four clocks for the synchroniser
    task automatic edges(input bit ext, input int n);
        repeat (2 * n) begin
            @(posedge aclk);
            if (ext) ext_pin <= !ext_pin;
            else cap_pin <= !cap_pin;
            repeat (3) @(posedge aclk);
        end
    endtask
endmodule

// ### dv/input_capture_with_timebase_tb_top.sv
`timescale 1ns/1ps
`include "ict_defines.vh"
module input_capture_with_timebase_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        gate = 1'b0, idle = 1'b0, sleep = 1'b0;
    logic [15:0] t2 = 16'h0, t4 = 16'h0, t5 = 16'h0, v;
    wire         awready, wready, bvalid, arready, rvalid, irq, cap, ext;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          err_count = 0, checks_done = 0;

    always #10 aclk = ~aclk;

    ict_capture_timer i_ict_capture_timer (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .timer_external_clock_pin(ext), .timer_gate_pin(gate), .capture_input(cap),
        .idle_mode(idle), .sleep_mode(sleep), .timer2_count(t2),
        .timer4_count(t4), .timer5_count(t5), .irq(irq)
    );
    ict_pin_model i_ict_pin_model (.aclk(aclk), .cap_pin(cap), .ext_pin(ext));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bus cycles, ready lines held high throughout
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        awaddr <= {27'h0, a};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [4:0] a);
        araddr <= {27'h0, a};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata[15:0];
    endtask
    task automatic t_regs;
        rd(`ICT_ADDR_TMR_CTRL);
        chk("tmr ctrl", v, `ICT_TMR_RESET);
        rd(`ICT_ADDR_CAP_CTRL);
        chk("cap ctrl", v, `ICT_CAP_RESET);
        wr(`ICT_ADDR_TMR_CTRL, 16'h7fff);
        rd(`ICT_ADDR_TMR_CTRL);
        chk("tmr bits", v, 16'h2076);
        wr(`ICT_ADDR_TMR_CTRL, 16'h0);
        wr(`ICT_ADDR_CAP_CTRL, 16'hfff8);
        rd(`ICT_ADDR_CAP_CTRL);
        chk("cap bits", v, 16'h3c60);
        wr(5'h1c, 16'h5555);
        chk("bad bresp", {14'h0, bresp}, {14'h0, `ICT_RESP_SLVERR});
        rd(5'h1c);
        chk("bad rresp", {14'h0, rresp}, {14'h0, `ICT_RESP_SLVERR});
    endtask
    // run the timer over a span, stop it, read the count
    task automatic tcase(input logic [15:0] c, input logic id, g, input int n, gap,
                         input logic [15:0] e);
        wr(`ICT_ADDR_TMR_COUNT, 16'h0);
        idle <= id;
        gate <= g;
        wr(`ICT_ADDR_TMR_CTRL, c);
        i_ict_pin_model.edges(1'b1, n);
        repeat (gap) @(posedge aclk);
        wr(`ICT_ADDR_TMR_CTRL, 16'h0);
        rd(`ICT_ADDR_TMR_COUNT);
        chk("timer count", v, e);
    endtask
    task automatic t_timer;
        tcase(16'h8000, 0, 0, 0, 37, 16'h28);
        tcase(16'h8010, 0, 0, 0, 33, 16'h4);
        tcase(16'h8020, 0, 0, 0, 285, 16'h4);
        tcase(16'h8030, 0, 0, 0, 1149, 16'h4);
        tcase(16'h8040, 0, 0, 0, 37, 16'h0);
        tcase(16'h8040, 0, 1, 0, 37, 16'h28);
        tcase(16'ha000, 1, 0, 0, 37, 16'h0);
        tcase(16'h8000, 1, 0, 0, 37, 16'h28);
        tcase(16'h8042, 0, 0, 5, 10, 16'h5);
        tcase(16'h8016, 0, 0, 16, 10, 16'h2);
    endtask
    // rewrites three cycles apart keep the divide-by-8 prescaler empty
    task automatic t_rewrite;
        wr(`ICT_ADDR_TMR_COUNT, 16'h0);
        repeat (10) wr(`ICT_ADDR_TMR_CTRL, 16'h8010);
        wr(`ICT_ADDR_TMR_CTRL, 16'h0);
        rd(`ICT_ADDR_TMR_COUNT);
        chk("rewrite count", v, 16'h0);
    endtask
    task automatic settle_drain(output int k);
        repeat (4) @(posedge aclk);
        k = 0;
        rd(`ICT_ADDR_CAP_CTRL);
        while (v[`ICT_CAP_BNE] === 1'b1 && k < 8) begin
            rd(`ICT_ADDR_CAP_BUF);
            k++;
            rd(`ICT_ADDR_CAP_CTRL);
        end
    endtask
    task automatic t_modes;
        logic [2:0] m[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
        int p[6] = '{2, 2, 2, 8, 16, 2};
        int e[6] = '{4, 2, 2, 2, 1, 0};
        int k;
        for (int i = 0; i < 6; i++) begin
            wr(`ICT_ADDR_CAP_CTRL, 16'h0);
            wr(`ICT_ADDR_CAP_CTRL, {13'h0, m[i]});
            i_ict_pin_model.edges(1'b0, p[i]);
            settle_drain(k);
            chk("captures", k[15:0], e[i][15:0]);
        end
    endtask
    task automatic t_tbase;
        logic [2:0] c[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
        logic [15:0] e[5] = '{16'h1234, 16'h4567, 16'h789a, 16'h0abc, 16'h0};
        t2 <= 16'h1234;
        t4 <= 16'h4567;
        t5 <= 16'h789a;
        wr(`ICT_ADDR_TMR_COUNT, 16'h0abc);
        for (int i = 0; i < 5; i++) begin
            wr(`ICT_ADDR_CAP_CTRL, 16'h0);
            wr(`ICT_ADDR_CAP_CTRL, {3'h0, c[i], 7'h0, `ICT_MODE_RISE});
            i_ict_pin_model.edges(1'b0, 1);
            repeat (4) @(posedge aclk);
            rd(`ICT_ADDR_CAP_CTRL);
            chk("not empty", v[`ICT_CAP_BNE], 1'b1);
            rd(`ICT_ADDR_CAP_BUF);
            chk("captured", v, e[i]);
            rd(`ICT_ADDR_CAP_CTRL);
            chk("empty", v[`ICT_CAP_BNE], 1'b0);
        end
    endtask
    // system timebase step between two rises, then idle halt stops captures
    task automatic t_halt;
        logic [15:0] w;
        int k;
        wr(`ICT_ADDR_CAP_CTRL, 16'h0);
        wr(`ICT_ADDR_CAP_CTRL, {3'h0, `ICT_TB_SYS, 7'h0, `ICT_MODE_RISE});
        i_ict_pin_model.edges(1'b0, 2);
        repeat (4) @(posedge aclk);
        rd(`ICT_ADDR_CAP_BUF);
        w = v;
        rd(`ICT_ADDR_CAP_BUF);
        chk("sys step", v - w, 16'h8);
        idle <= 1'b1;
        wr(`ICT_ADDR_CAP_CTRL, {3'h1, `ICT_TB_SYS, 7'h0, `ICT_MODE_RISE});
        i_ict_pin_model.edges(1'b0, 2);
        settle_drain(k);
        chk("halted captures", k[15:0], 16'h0);
        idle <= 1'b0;
    endtask
    // nth capture raises the line, then overflow, masking, wake mode
    task automatic t_irq;
        int k;
        wr(`ICT_ADDR_IRQ_MASK, 16'h1);
        for (int c = 0; c < 4; c++) begin
            wr(`ICT_ADDR_CAP_CTRL, 16'h0);
            wr(`ICT_ADDR_IRQ_STAT, 16'h7);
            wr(`ICT_ADDR_CAP_CTRL, {9'h0, c[1:0], 2'h0, `ICT_MODE_RISE});
            i_ict_pin_model.edges(1'b0, c);
            repeat (4) @(posedge aclk);
            chk("irq early", irq, 1'b0);
            i_ict_pin_model.edges(1'b0, 1);
            repeat (4) @(posedge aclk);
            chk("irq due", irq, 1'b1);
        end
        wr(`ICT_ADDR_IRQ_MASK, 16'h0);
        wr(`ICT_ADDR_IRQ_STAT, 16'h7);
        i_ict_pin_model.edges(1'b0, 1);
        repeat (4) @(posedge aclk);
        chk("irq masked", irq, 1'b0);
        rd(`ICT_ADDR_CAP_CTRL);
        chk("overflow", v[`ICT_CAP_OVF], 1'b1);
        wr(`ICT_ADDR_IRQ_MASK, 16'h4);
        @(posedge aclk);
        chk("irq overflow", irq, 1'b1);
        wr(`ICT_ADDR_IRQ_STAT, 16'h4);
        @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
        wr(`ICT_ADDR_CAP_CTRL, 16'h0);
        wr(`ICT_ADDR_IRQ_MASK, 16'h1);
        wr(`ICT_ADDR_IRQ_STAT, 16'h7);
        chk("irq before wake", irq, 1'b0);
        sleep <= 1'b1;
        wr(`ICT_ADDR_CAP_CTRL, {13'h0, `ICT_MODE_WAKE});
        i_ict_pin_model.edges(1'b0, 1);
        settle_drain(k);
        chk("irq wake", irq, 1'b1);
        chk("wake no capture", k[15:0], 16'h0);
        sleep <= 1'b0;
        // timer wrap raises its own status bit
        wr(`ICT_ADDR_IRQ_MASK, 16'h2);
        chk("irq unwrapped", irq, 1'b0);
        wr(`ICT_ADDR_TMR_COUNT, 16'hfffe);
        wr(`ICT_ADDR_TMR_CTRL, 16'h8000);
        wr(`ICT_ADDR_TMR_CTRL, 16'h0);
        chk("irq wrap", irq, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_timer;
        t_rewrite;
        t_modes;
        t_tbase;
        t_halt;
        t_irq;
        report_and_stop;
    end
    // hang guard, well past the expected run length
    initial begin
        #1000000;
        err_count++;
        report_and_stop;
    end
endmodule
